// *** sdt_pkg.sv ***
// Constants, register map and types of the serial bus decode trigger
//
// What this block does
// R1 - Words are 4 to 32 bits long, 8 bits after reset.
// R2 - Minimum clock idle time spans 50 ns to 10 s, 1 ms after reset.
// R3 - In idle-time framing a quiet clock closes the frame, activity opens one.
// R4 - Each bus line picks its source from 29 channel inputs.
// R5 - With filtering on, only frames meeting enabled conditions pass; off at reset.
// R6 - A field compares its word with low value, and high value for ranges.
// R7 - Each field holds a bit-state pattern, zero after reset.
// R8 - One enable per error type, on at reset; enabled error frames pass.
// R9 - Per-field condition enable, off at reset; disabled fields never block.
// R10 - Per-frame-type check enable, on at reset, decides taking part.
// R11 - Index bounds span 1 to 65535, defaulting to 1 and 65535.
// R12 - Index operator is equal, in-range or range; in-range at reset.
// R13 - Trigger on frame begin, frame end, or pattern on either data line.
// R14 - Trigger pattern also serves as lower bound of a pattern range.
// R15 - Pattern skips 1 to 4096 bits or words per alignment, default 1.
// R16 - Trigger settings act on the selected source bus, chosen first.
// R17 - Four independent decoders, each with its own settings.
// R18 - Framing by chip select or clock idle time; chip select at reset.
// R19 - Most or least significant bit first; most first at reset.
// R20 - Pattern at word boundaries or any bit; word boundaries at reset.
// R21 - Trigger is a single-cycle pulse on the sampling clock.
// R22 - Bus lines are synchronised before edge detection.
package sdt_pkg;
	// ********************************************************
	// Sizes and timing
	// ********************************************************
	localparam int NBUS = 4;
	localparam int NFLD = 2;
	localparam int NSRC = 29;
	localparam int CLK_MHZ = 250;
	localparam int WLEN_MIN = 4;
	localparam int WLEN_MAX = 32;
	localparam int SKIP_MAX = 4096;
	localparam int IDLE_MIN_NS = 50;
	localparam int IDLE_DEF_US = 1000;
	localparam int IDLE_MAX_S = 10;
	localparam logic [31:0] IDLE_MIN_CYC =
		32'((IDLE_MIN_NS * CLK_MHZ + 999) / 1000);
	localparam int IDLE_DEF_CYC = IDLE_DEF_US * CLK_MHZ;
	localparam logic [31:0] IDLE_MAX_CYC =
		32'(64'(IDLE_MAX_S) * 64'd1000000 * 64'(CLK_MHZ));

	// ********************************************************
	// Register map, word indices
	// ********************************************************
	localparam logic [3:0] R_CFG = 4'h0;
	localparam logic [3:0] R_SRC = 4'h1;
	localparam logic [3:0] R_TMO = 4'h2;
	localparam logic [3:0] R_STAT = 4'h3;
	localparam logic [3:0] R_FLD = 4'h4;
	localparam logic [3:0] FLD_STEP = 4'h5;
	localparam logic [3:0] NREG = 4'he;
	localparam logic [3:0] F_CTL = 4'h0;
	localparam logic [3:0] F_LO = 4'h1;
	localparam logic [3:0] F_HI = 4'h2;
	localparam logic [3:0] F_BITS = 4'h3;
	localparam logic [3:0] F_IDX = 4'h4;
	localparam logic [1:0] T_CTL = 2'h0;
	localparam logic [1:0] T_LO = 2'h1;
	localparam logic [1:0] T_HI = 2'h2;
	localparam logic [1:0] T_SKIP = 2'h3;

	// ********************************************************
	// Field positions, masks and reset values
	// ********************************************************
	localparam int CFG_WLEN = 0;
	localparam int CFG_MODE = 6;
	localparam int CFG_ORDER = 7;
	localparam int CFG_CSPOL = 8;
	localparam int CFG_FILT = 9;
	localparam int CFG_FCHK = 10;
	localparam int CFG_ERRE = 11;
	localparam int SRC_SCLK = 0;
	localparam int SRC_CS = 8;
	localparam int SRC_MOSI = 16;
	localparam int SRC_MISO = 24;
	localparam int FC_EN = 0;
	localparam int FC_DOP = 1;
	localparam int FC_IOP = 4;
	localparam int FC_BITS = 6;
	localparam int TC_SRC = 0;
	localparam int TC_TYPE = 2;
	localparam int TC_ALIGN = 4;
	localparam int TC_RANGE = 5;
	localparam logic [31:0] CFG_RST = 32'h0000_0c08;
	localparam logic [31:0] SRC_RST = 32'h0302_0100;
	localparam logic [31:0] SRC_MASK = 32'h1f1f_1f1f;
	localparam logic [31:0] FCTL_RST = 32'h0000_0010;
	localparam logic [31:0] FCTL_MASK = 32'h0000_007f;
	localparam logic [31:0] IDX_RST = 32'hffff_0001;
	localparam logic [31:0] TCTL_MASK = 32'h0000_003f;
	localparam logic [31:0] TSKIP_RST = 32'h0000_0001;

	// ********************************************************
	// Operators and trigger kinds
	// ********************************************************
	typedef enum logic [2:0] {
		DOP_EQ, DOP_NE, DOP_LT, DOP_LE, DOP_GT, DOP_GE,
		within_bounds_op, outside_bounds_op
	} sdt_dop_type;
	typedef enum logic [1:0] {IOP_EQ, IOP_IN, IOP_RANGE} sdt_iop_type;
	typedef enum logic [1:0] {
		frame_begin_trigger, frame_finish_trigger, TRG_MOSI, TRG_MISO
	} sdt_trg_type;
endpackage

// *** sdt_sync.sv ***
// Two-flop synchroniser for the channel inputs
`timescale 1ns/1ns
module sdt_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // sdt_sync

// *** sdt_top.sv ***
// Four-bus serial decoder, frame filter and trigger with APB registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
module sdt_top
	import sdt_pkg::*;
#(
	parameter int IDLE_DEF = IDLE_DEF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] chan_ana,
	input wire logic [15:0] chan_dig,
	input wire logic [4:0] chan_math,
	input wire logic [3:0] chan_ref,
	output logic [NBUS-1:0] word_valid,
	output logic [NBUS-1:0] word_err,
	output logic [NBUS*32-1:0] word_mosi,
	output logic [NBUS*32-1:0] word_miso,
	output logic trig_out
);
	// Defaults below the idle floor could never be reached
	if (IDLE_DEF < int'(IDLE_MIN_CYC) || IDLE_DEF > 32'h7fff_ffff)
		$error("IDLE_DEF out of range");

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic pick(input logic [NSRC-1:0] s,
		input logic [4:0] k);
		return (k < 5'(NSRC)) ? s[k] : 1'b0;
	endfunction

	function automatic logic [31:0] wmask(input logic [5:0] w);
		return ~(32'hffff_ffff << w);
	endfunction

	function automatic logic [15:0] atleast1(input logic [15:0] v);
		return (v == 16'h0) ? 16'h1 : v;
	endfunction

	function automatic logic [3:0] fsub(input logic [3:0] i);
		return 4'((i - R_FLD) % FLD_STEP);
	endfunction

	function automatic logic [31:0] rst_val(input logic [3:0] i);
		rst_val = 32'h0;
		if (i == R_CFG)
			rst_val = CFG_RST;
		else if (i == R_SRC)
			rst_val = SRC_RST;
		else if (i == R_TMO)
			rst_val = 32'(IDLE_DEF);
		else if (i >= R_FLD && fsub(i) == F_CTL)
			rst_val = FCTL_RST;
		else if (i >= R_FLD && fsub(i) == F_IDX)
			rst_val = IDX_RST;
	endfunction

	// Clamping on write keeps word length, idle time, index bounds and skip count legal
	function automatic logic [31:0] wval(input logic [3:0] i,
		input logic [31:0] d);
		logic [5:0] w;
		w = d[CFG_WLEN +: 6];
		wval = d;
		if (i == R_CFG) begin
			if (w < 6'(WLEN_MIN))
				w = 6'(WLEN_MIN); // R1
			else if (w > 6'(WLEN_MAX))
				w = 6'(WLEN_MAX); // R1
			wval = {20'h0, d[11:6], w};
		end else if (i == R_SRC)
			wval = d & SRC_MASK;
		else if (i == R_TMO) begin
			if (d < IDLE_MIN_CYC)
				wval = IDLE_MIN_CYC; // R2
			else if (d > IDLE_MAX_CYC)
				wval = IDLE_MAX_CYC; // R2
		end else if (i == R_STAT)
			wval = 32'h0;
		else if (fsub(i) == F_CTL)
			wval = d & FCTL_MASK;
		else if (fsub(i) == F_IDX)
			wval = {atleast1(d[31:16]), atleast1(d[15:0])}; // R11
	endfunction

	function automatic logic [31:0] tval(input logic [1:0] i,
		input logic [31:0] d);
		tval = d;
		if (i == T_CTL)
			tval = d & TCTL_MASK;
		else if (i == T_SKIP) begin
			if (d == 32'h0)
				tval = 32'h1; // R15
			else if (d > 32'(SKIP_MAX))
				tval = 32'(SKIP_MAX); // R15
		end
	endfunction

	function automatic logic dmatch(input logic [2:0] op,
		input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		case (sdt_dop_type'(op))
			DOP_EQ: dmatch = v == lo;
			DOP_NE: dmatch = v != lo;
			DOP_LT: dmatch = v < lo;
			DOP_LE: dmatch = v <= lo;
			DOP_GT: dmatch = v > lo;
			DOP_GE: dmatch = v >= lo;
			within_bounds_op: dmatch = v >= lo && v <= hi;
			outside_bounds_op: dmatch = v < lo || v > hi;
			default: dmatch = 1'b0;
		endcase
	endfunction

	function automatic logic imatch(input logic [1:0] op,
		input logic [15:0] n, input logic [15:0] lo,
		input logic [15:0] hi);
		case (sdt_iop_type'(op))
			IOP_EQ: imatch = n == lo;
			IOP_IN: imatch = n >= lo && n <= hi;
			IOP_RANGE: imatch = n < lo || n > hi;
			default: imatch = 1'b0;
		endcase
	endfunction

	// Disabled field never blocks a frame
	function automatic logic fld_ok(input logic [31:0] c,
		input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] bs, input logic [31:0] ix,
		input logic [31:0] v, input logic [15:0] n);
		logic d;
		d = dmatch(c[FC_DOP +: 3], v, lo, hi); // R6
		d = d & imatch(c[FC_IOP +: 2], n, ix[15:0], ix[31:16]); // R12
		d = d & (~c[FC_BITS] | (v == bs)); // R7
		return ~c[FC_EN] | d; // R9
	endfunction

	// ********************************************************
	// State
	// ********************************************************
	logic [31:0] reg_r [NBUS*16];
	logic [31:0] trg_r [4];
	logic [NSRC-1:0] src_s;
	logic [NBUS-1:0] in_frm_r, sclk_d_r, wdone_r, perr_r, bitv_r;
	logic [NBUS-1:0] fst, fen, ev_mo, ev_mi;
	logic [31:0] mo_sh_r [NBUS];
	logic [31:0] mi_sh_r [NBUS];
	logic [31:0] mo_win_r [NBUS];
	logic [31:0] mi_win_r [NBUS];
	logic [31:0] idle_r [NBUS];
	logic [5:0] bcnt_r [NBUS];
	logic [15:0] widx_r [NBUS];
	logic [12:0] tbits_r [NBUS];
	logic [31:0] rdata;
	logic ok, tsel;
	logic [1:0] warm_r;
	logic [1:0] tsrc;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ********************************************************
	// Channel synchronisers
	// ********************************************************
	sdt_sync #(
		.W(NSRC)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d({chan_ref, chan_math, chan_dig, chan_ana}), // R22
		.q(src_s)
	);

	// A select pin idles high, so frames wait for real pin data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			warm_r <= 2'h0;
		else if (ce)
			warm_r <= {warm_r[0], 1'b1}; // R22
	end

	// ********************************************************
	// APB slave
	// ********************************************************
	// Zero wait states; a stalled clock enable stalls the bus too
	assign pready = ce;
	assign pslverr = psel & penable & ~ok;

	// Decode and read mux
	always_comb begin
		rdata = 32'h0;
		ok = 1'b1;
		if (paddr[11:9] != 3'h0 || paddr[1:0] != 2'h0)
			ok = 1'b0;
		else if (!paddr[8]) begin
			if (paddr[5:2] == R_STAT)
				rdata = {15'h0, in_frm_r[paddr[7:6]], widx_r[paddr[7:6]]};
			else if (paddr[5:2] < NREG)
				rdata = reg_r[paddr[7:2]];
			else
				ok = 1'b0;
		end else if (paddr[7:4] == 4'h0)
			rdata = trg_r[paddr[3:2]];
		else
			ok = 1'b0;
	end

	// Read data caught in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (ce && psel && !penable)
			prdata <= rdata;
	end

	// Register writes at the completing access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NBUS * 16; i++)
				reg_r[i] <= rst_val(i[3:0]); // R17
			for (int i = 0; i < 4; i++)
				trg_r[i] <= (i == int'(T_SKIP)) ? TSKIP_RST : 32'h0;
		end else if (ce && psel && penable && pwrite && ok) begin
			if (!paddr[8])
				reg_r[paddr[7:2]] <= wval(paddr[5:2], pwdata);
			else
				trg_r[paddr[3:2]] <= tval(paddr[3:2], pwdata);
		end
	end

	// ********************************************************
	// Per-bus decoders
	// ********************************************************
	for (genvar b = 0; b < NBUS; b++) begin : g_bus
		logic [31:0] cfg, src, tmo, mo0, mi0, mo_v, mi_v;
		logic [5:0] wl, bc0;
		logic sck, cs_act, mo_b, mi_b, rise, tk, pass, wpos, bpos;
		logic bitmode;
		logic [NFLD-1:0] fok;

		assign cfg = reg_r[b*16 + int'(R_CFG)];
		assign src = reg_r[b*16 + int'(R_SRC)];
		assign tmo = reg_r[b*16 + int'(R_TMO)];
		assign wl = cfg[CFG_WLEN +: 6]; // R1

		// Line source multiplexers
		assign sck = pick(src_s, src[SRC_SCLK +: 5]); // R4
		assign cs_act = pick(src_s, src[SRC_CS +: 5]) ~^ cfg[CFG_CSPOL];
		assign mo_b = pick(src_s, src[SRC_MOSI +: 5]); // R4
		assign mi_b = pick(src_s, src[SRC_MISO +: 5]); // R4
		assign rise = sck & ~sclk_d_r[b]; // R22

		// Frame open and close conditions
		always_comb begin
			if (cfg[CFG_MODE]) begin
				fst[b] = rise & ~in_frm_r[b]; // R3
				fen[b] = in_frm_r[b] & ~rise & (idle_r[b] >= tmo); // R3
			end else begin
				fst[b] = cs_act & ~in_frm_r[b] & warm_r[1]; // R18
				fen[b] = ~cs_act & in_frm_r[b]; // R18
			end
		end

		// Every clock rise in a frame carries one bit
		assign tk = rise & (cfg[CFG_MODE] | cs_act);
		assign bc0 = fst[b] ? 6'h0 : bcnt_r[b];
		assign mo0 = (bc0 == 6'h0) ? 32'h0 : mo_sh_r[b];
		assign mi0 = (bc0 == 6'h0) ? 32'h0 : mi_sh_r[b];

		// Frame state and idle timer
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				in_frm_r[b] <= 1'b0;
				sclk_d_r[b] <= 1'b0;
				idle_r[b] <= 32'h0;
				perr_r[b] <= 1'b0;
			end else if (ce) begin
				sclk_d_r[b] <= sck;
				if (sck != sclk_d_r[b])
					idle_r[b] <= 32'h0;
				else if (idle_r[b] != 32'hffff_ffff)
					idle_r[b] <= idle_r[b] + 32'h1; // R2
				perr_r[b] <= fen[b] & (bcnt_r[b] != 6'h0); // R8
				if (fst[b])
					in_frm_r[b] <= 1'b1;
				else if (fen[b])
					in_frm_r[b] <= 1'b0;
			end
		end

		// Word assembly
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				bcnt_r[b] <= 6'h0;
				widx_r[b] <= 16'h0;
				mo_sh_r[b] <= 32'h0;
				mi_sh_r[b] <= 32'h0;
				wdone_r[b] <= 1'b0;
			end else if (ce) begin
				wdone_r[b] <= 1'b0;
				if (fst[b])
					widx_r[b] <= 16'h0;
				if (tk) begin
					if (cfg[CFG_ORDER]) begin
						mo_sh_r[b] <= mo0 | (32'(mo_b) << bc0); // R19
						mi_sh_r[b] <= mi0 | (32'(mi_b) << bc0); // R19
					end else begin
						mo_sh_r[b] <= {mo0[30:0], mo_b}; // R19
						mi_sh_r[b] <= {mi0[30:0], mi_b}; // R19
					end
					if (bc0 + 6'h1 == wl) begin
						bcnt_r[b] <= 6'h0; // R1
						wdone_r[b] <= 1'b1;
						if (widx_r[b] != 16'hffff)
							widx_r[b] <= widx_r[b] + 16'h1;
					end else
						bcnt_r[b] <= bc0 + 6'h1;
				end else if (fst[b] || fen[b])
					bcnt_r[b] <= 6'h0;
			end
		end

		// Sliding window in arrival order for bit alignment
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mo_win_r[b] <= 32'h0;
				mi_win_r[b] <= 32'h0;
				tbits_r[b] <= 13'h0;
				bitv_r[b] <= 1'b0;
			end else if (ce) begin
				bitv_r[b] <= tk;
				if (tk) begin
					mo_win_r[b] <= {mo_win_r[b][30:0], mo_b};
					mi_win_r[b] <= {mi_win_r[b][30:0], mi_b};
				end
				if (fst[b])
					tbits_r[b] <= {12'h0, tk};
				else if (tk && tbits_r[b] != 13'h1fff)
					tbits_r[b] <= tbits_r[b] + 13'h1;
			end
		end

		// Field conditions: field 0 watches MOSI, field 1 MISO
		for (genvar f = 0; f < NFLD; f++) begin : g_fld
			localparam int B = b*16 + int'(R_FLD) + f*int'(FLD_STEP);
			assign fok[f] = fld_ok(reg_r[B + int'(F_CTL)],
				reg_r[B + int'(F_LO)], reg_r[B + int'(F_HI)],
				reg_r[B + int'(F_BITS)], reg_r[B + int'(F_IDX)],
				(f == 0) ? mo_sh_r[b] : mi_sh_r[b], widx_r[b]);
			property p_fld_off;
				!reg_r[B + int'(F_CTL)][FC_EN] |-> fok[f];
			endproperty
			a_fld_off: assert property (p_fld_off) // R9
				else $error("disabled field blocked a word");
		end

		// Error frames pass on their enable, others on the check enable and all fields
		assign pass = ~cfg[CFG_FILT] | (perr_r[b] ? cfg[CFG_ERRE] // R8
			: cfg[CFG_FCHK] & (&fok)); // R10

		// Decoded word output
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				word_valid[b] <= 1'b0;
				word_err[b] <= 1'b0;
				word_mosi[b*32 +: 32] <= 32'h0;
				word_miso[b*32 +: 32] <= 32'h0;
			end else if (ce) begin
				word_valid[b] <= (wdone_r[b] | perr_r[b]) & pass; // R5
				if (wdone_r[b] || perr_r[b]) begin
					word_err[b] <= perr_r[b];
					word_mosi[b*32 +: 32] <= mo_sh_r[b];
					word_miso[b*32 +: 32] <= mi_sh_r[b];
				end
			end
		end

		// Pattern candidates after the skip count
		assign bitmode = trg_r[T_CTL][TC_ALIGN];
		assign wpos = widx_r[b] >= trg_r[T_SKIP][15:0]; // R15
		assign bpos = 32'(tbits_r[b]) + 32'h1 >=
			trg_r[T_SKIP] + 32'(wl); // R15
		assign mo_v = bitmode ? mo_win_r[b] & wmask(wl) : mo_sh_r[b];
		assign mi_v = bitmode ? mi_win_r[b] & wmask(wl) : mi_sh_r[b];
		assign ev_mo[b] = (bitmode ? bitv_r[b] & bpos // R20
			: wdone_r[b] & wpos) & pcmp(mo_v);
		assign ev_mi[b] = (bitmode ? bitv_r[b] & bpos // R20
			: wdone_r[b] & wpos) & pcmp(mi_v);

		// Checks on this decoder
		sequence s_ev;
			ce && (wdone_r[b] || perr_r[b]);
		endsequence
		property p_wlen;
			wl >= 6'(WLEN_MIN) && wl <= 6'(WLEN_MAX);
		endproperty
		a_wlen: assert property (p_wlen) // R1
			else $error("word length out of range");
		property p_idle_close;
			ce && cfg[CFG_MODE] && in_frm_r[b] && !rise &&
				idle_r[b] >= tmo |=> !in_frm_r[b];
		endproperty
		a_idle_close: assert property (p_idle_close) // R3
			else $error("idle clock did not close the frame");
		property p_cs_frame;
			ce && warm_r[1] && !cfg[CFG_MODE] |=>
				in_frm_r[b] == $past(cs_act);
		endproperty
		a_cs_frame: assert property (p_cs_frame) // R18
			else $error("frame does not follow chip select");
		property p_filt_off;
			!cfg[CFG_FILT] ##0 s_ev |=> word_valid[b];
		endproperty
		a_filt_off: assert property (p_filt_off) // R5
			else $error("unfiltered word was dropped");
		property p_frame_off;
			cfg[CFG_FILT] && !cfg[CFG_FCHK] && !perr_r[b] ##0 s_ev
				|=> !word_valid[b];
		endproperty
		a_frame_off: assert property (p_frame_off) // R10
			else $error("unchecked frame type passed");
		property p_edge_one;
			ce && rise |=> !rise;
		endproperty
		a_edge_one: assert property (p_edge_one) // R22
			else $error("clock rise seen twice");
	end

	// ********************************************************
	// Trigger
	// ********************************************************
	function automatic logic pcmp(input logic [31:0] v);
		if (trg_r[T_CTL][TC_RANGE])
			return v >= trg_r[T_LO] && v <= trg_r[T_HI]; // R14
		return v == trg_r[T_LO]; // R14
	endfunction

	// Only the selected source bus can fire
	assign tsrc = trg_r[T_CTL][TC_SRC +: 2]; // R16
	always_comb begin
		case (sdt_trg_type'(trg_r[T_CTL][TC_TYPE +: 2]))
			frame_begin_trigger: tsel = fst[tsrc]; // R13
			frame_finish_trigger: tsel = fen[tsrc]; // R13
			TRG_MOSI: tsel = ev_mo[tsrc]; // R13
			TRG_MISO: tsel = ev_mi[tsrc]; // R13
			default: tsel = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			trig_out <= 1'b0;
		else if (ce)
			trig_out <= tsel; // R21
	end

	property p_trig_pulse;
		ce && trig_out |=> !trig_out;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) // R21
		else $error("trigger longer than one cycle");
	property p_start_trig;
		ce && trg_r[T_CTL][TC_TYPE +: 2] == 2'h0 && fst[tsrc]
			|=> trig_out;
	endproperty
	a_start_trig: assert property (p_start_trig) // R13
		else $error("frame begin did not trigger");
endmodule // sdt_top

// *** sdt_bus_model.sv ***
// Serial bus master and slave model driving one set of observed lines
`timescale 1ns/1ns
module sdt_bus_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	output logic miso
);
	// Idle bus: clock stands low, select inactive
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		miso = 1'b1;
	end
	// Select setup and hold around the bits, active low
	task automatic sel(input logic on);
		#40 cs_n = ~on;
	endtask
	// Bits go out high bit first, one 80 ns clock each
	// Delays are multiples of 4 so the caller's phase keeps edges apart
	task automatic xfer(input logic [31:0] mo, mi, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			#4 mosi = mo[i];
			miso = mi[i];
			#36 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
		#4 mosi = ~mosi; // Released lines must not keep the last bit
		miso = ~miso;
	endtask
endmodule // sdt_bus_model

// *** spi_bus_decode_trigger_test.sv ***
// Self-checking bench of the serial bus decode trigger
`timescale 1ns/1ns
module spi_bus_decode_trigger_test;
	import sdt_pkg::*;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, trig_out;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] chan_dig;
	logic [4:0] chan_math;
	logic [3:0] chan_ref;
	wire [3:0] chan_ana;
	wire m_sclk, m_cs_n, m_mosi, m_miso;
	logic [NBUS-1:0] word_valid, word_err;
	logic [NBUS*32-1:0] word_mosi, word_miso;
	int fail_count, num_checks, trig_count;
	logic order, idle_mode;
	logic [64:0] exp_q[$];
	logic [7:0] lo_t [8] = '{8'h40, 8'h40, 8'h41, 8'h40, 8'h40, 8'h41,
		8'h30, 8'h30};
	logic [7:0] pass_t = 8'h4d;
	logic [3:0] trg_t = 4'b0111;

	// Bus 0 default sources are channel inputs 0..3
	assign chan_ana = {m_miso, m_mosi, m_cs_n, m_sclk};
	sdt_bus_model model_u (.sclk(m_sclk), .cs_n(m_cs_n), .mosi(m_mosi),
		.miso(m_miso));
	sdt_top #(.IDLE_DEF(100)) dut_u (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chan_ana(chan_ana), .chan_dig(chan_dig),
		.chan_math(chan_math), .chan_ref(chan_ref),
		.word_valid(word_valid), .word_err(word_err),
		.word_mosi(word_mosi), .word_miso(word_miso),
		.trig_out(trig_out));

	// ****************************************************
	// Clock, checking helpers and monitors
	// ****************************************************
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic fail(input string m);
		fail_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic cmp_val(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) fail(m);
	endtask
	task automatic cmp_word(input logic [64:0] exp);
		num_checks++;
		if ({word_err[0], word_miso[31:0], word_mosi[31:0]} !== exp) begin
			fail("word mismatch");
		end
	endtask
	// Unused channels toggle so the source selection is exercised
	always @(posedge pclk) begin
		chan_dig <= 16'($urandom);
		chan_math <= 5'($urandom);
		chan_ref <= 4'($urandom);
	end
	// Outputs are registered, so they are read on the falling edge
	always @(negedge pclk) begin
		if (trig_out === 1'b1) trig_count++;
		if (word_valid[0] === 1'b1) begin
			if (exp_q.size() == 0) fail("unexpected word");
			else cmp_word(exp_q.pop_front());
		end
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail("watchdog expired");
		report_and_stop();
	end

	// ****************************************************
	// Bus tasks
	// ****************************************************
	// APB transfer; entered and left just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		cmp_val(q, x, "read data");
		cmp_val({31'h0, e}, 32'h0, "read error");
	endtask
	task automatic bad(input logic [11:0] a);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		cmp_val({31'h0, e}, 32'h1, "no slave error");
		cmp_val(q, 32'h0, "refused read data");
	endtask
	task automatic setcfg(input int len, input logic md, od, ft, fc, er);
		idle_mode = md;
		order = od;
		wr(12'h000, {20'h0, er, fc, ft, 1'b0, od, md, 6'(len)});
	endtask
	// Expected word as assembled in the configured bit order
	function automatic logic [31:0] rv(input logic [31:0] v, input int n);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < n; i++) r[i] = order ? v[n-1-i] : v[i];
		return r;
	endfunction
	// Two full words then k stray bits; p marks which results pass
	task automatic frame(input logic [31:0] a, b, c, d, input int n, k,
		input logic [2:0] p);
		if (p[0]) exp_q.push_back({1'b0, rv(b, n), rv(a, n)});
		if (p[1]) exp_q.push_back({1'b0, rv(d, n), rv(c, n)});
		if (p[2]) exp_q.push_back({1'b1, rv(b, k), rv(a, k)});
		trig_count = 0;
		#1;
		if (!idle_mode) model_u.sel(1'b1);
		model_u.xfer(a, b, n);
		model_u.xfer(c, d, n);
		if (k > 0) model_u.xfer(a, b, k);
		if (!idle_mode) model_u.sel(1'b0);
		// Longer than the 100-cycle idle time, so the frame closes
		repeat (150) @(posedge pclk);
		cmp_val(32'(exp_q.size()), 32'h0, "words missing");
	endtask

	// ****************************************************
	// Test sequence
	// ****************************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{chan_dig, chan_math, chan_ref, order, idle_mode} = '0;
		ce = 1'b1;
		fail_count = 0;
		num_checks = 0;
		trig_count = 0;
		void'($urandom(84));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h000, 32'h0000_0c08);
		rd(12'h0c0, 32'h0000_0c08);
		rd(12'h004, 32'h0302_0100);
		rd(12'h008, 32'd100);
		rd(12'h010, 32'h0000_0010);
		rd(12'h01c, 32'h0);
		rd(12'h020, 32'hffff_0001);
		rd(12'h100, 32'h0);
		rd(12'h10c, 32'h1);
		bad(12'h204);
		wr(12'h008, 32'd5);
		rd(12'h008, 32'd13);
		wr(12'h008, 32'd100);
		$display("test reset_values done");
		// Word lengths at both limits, both bit orders
		foreach (lo_t[i]) begin
			if (i < 4) begin
				setcfg(i == 0 ? 8 : i == 1 ? 4 : i == 2 ? 32 : 13, 1'b0,
					i[0], 1'b0, 1'b1, 1'b1);
				frame($urandom, $urandom, $urandom, $urandom,
					i == 0 ? 8 : i == 1 ? 4 : i == 2 ? 32 : 13, 0, 3'b011);
				cmp_val(32'(trig_count), 32'h1, "begin trigger");
			end
		end
		$display("test word_assembly done");
		setcfg(8, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		frame($urandom, $urandom, $urandom, $urandom, 8, 3, 3'b111);
		setcfg(8, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		frame($urandom, $urandom, $urandom, $urandom, 8, 5, 3'b111);
		$display("test framing done");
		// Every data operator against the same word
		setcfg(8, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
		wr(12'h018, 32'h50);
		foreach (lo_t[i]) begin
			wr(12'h014, {24'h0, lo_t[i]});
			wr(12'h010, 32'h11 | (i << 1));
			frame(32'h40, $urandom, 32'h40, $urandom, 8, 0,
				{1'b0, {2{pass_t[i]}}});
		end
		wr(12'h010, 32'h10);
		frame(32'h22, 32'h0, 32'h22, 32'h0, 8, 0, 3'b011);
		wr(12'h014, 32'h0);
		wr(12'h018, 32'hff);
		wr(12'h020, 32'hffff_0002);
		wr(12'h010, 32'h0d);
		frame(32'h11, 32'h0, 32'h12, 32'h0, 8, 0, 3'b010);
		wr(12'h010, 32'h2d);
		frame(32'h11, 32'h0, 32'h12, 32'h0, 8, 0, 3'b001);
		wr(12'h020, 32'hffff_0001);
		wr(12'h01c, 32'h5a);
		wr(12'h010, 32'h5d);
		frame(32'h5a, 32'h0, 32'h11, 32'h0, 8, 0, 3'b001);
		setcfg(8, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		frame($urandom, $urandom, $urandom, $urandom, 8, 3, 3'b100);
		setcfg(8, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		frame($urandom, $urandom, $urandom, $urandom, 8, 3, 3'b000);
		$display("test filter done");
		// Each trigger kind, pattern skipping the first word
		setcfg(8, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		wr(12'h104, 32'h3c);
		wr(12'h10c, 32'h2);
		for (int t = 0; t < 4; t++) begin
			wr(12'h100, 32'(t) << 2);
			frame(32'h3c, 32'h3c, 32'h3c, 32'h55, 8, 0, 3'b011);
			cmp_val(32'(trig_count), {31'h0, trg_t[t]}, "trigger count");
		end
		wr(12'h108, 32'hf0);
		wr(12'h100, 32'h38);
		frame(32'h3c, 32'h0, 32'h3c, 32'h0, 8, 0, 3'b011);
		cmp_val(32'(trig_count), 32'h6, "bit pattern count");
		$display("test trigger done");
		report_and_stop();
	end
endmodule // spi_bus_decode_trigger_test
